//--- design/dcp_core.sv
// Purpose: ddr3 device-side command protocol state keeper
// Assumes: pins synchronous to core_clk_i, rst_i synchronous active high
// Notes:   no data path; reports decoded activity and state
//
// How it works
// - zq short: cke high twice, cs low, ras/cas high, we low, a10 low.
// - commands decoded only from cs, ras, cas, we, cke and a10 (zq short vs long) at clock edge.
// - bank and address widths are fixed package constants.
// - bank address picks bank, or mode register for mode set.
// - running bursts complete unless a later read or write reloads the counter, which can cut them short.
// - fixed or on-the-fly burst length chosen by mode register.
// - no refresh happens while powered down.
// - odt level does not affect decode or state.
// - termination is off in self refresh regardless of odt.
// - self refresh exit needs no prior running clock.
// - nop terminates nothing in progress.
// - deselect acts exactly like nop.
// - zq long is zq short with a10 high.
`timescale 1ns/10ps
module dcp_core
  import dcp_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire dcp_cmd_t           cmd_i,
  input  wire logic               odt_i,
  output logic [BANKS-1:0]        bank_open_o,
  output logic                    burst_busy_o,
  output logic                    self_refresh_o,
  output logic                    power_down_o,
  output logic                    term_on_o,
  output logic                    refresh_pulse_o,
  output logic                    zq_short_o,
  output logic                    zq_long_o,
  output logic [MR_N*MR_W-1:0]    mode_regs_o
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic           cke_q;
  dcp_op_t        op;
  logic [2:0]     burst_q, burst_d;
  logic [BANKS-1:0] bank_q, bank_d;
  logic [MR_W-1:0]  mr_q [MR_N];
  logic           sr_q, pd_q;

  dcp_decode u_dec (
    .cmd_i      (cmd_i),
    .cke_prev_i (cke_q),
    .op_o       (op)
  );

  wire            burst_run = (burst_q != 3'h0);
  wire [1:0]      bl_mode   = mr_q[0][MR0_BL_LO +: 2];
  // on-the-fly mode reads a12 per command, fixed mode uses the register
  wire            chop      = (bl_mode == MR0_BL_OTF) ? !cmd_i.addr[BC_BIT]
                                                      : (bl_mode == MR0_BL_BC4);
  wire [2:0]      burst_len = chop ? BURST4_CYC : BURST8_CYC;
  wire            rw_cmd    = (op == CMD_WR) || (op == CMD_RD);
  wire            mr_wr     = (op == CMD_MRS);
  // exit looks only at cke now, so no clock history before the exit is needed
  wire            sr_exit   = sr_q && cmd_i.cke;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    burst_d = burst_run ? burst_q - 3'h1 : 3'h0;
    if (rw_cmd && !sr_q && !pd_q) begin
      burst_d = burst_len;
    end
    bank_d = bank_q;
    case (op)
      CMD_ACT: bank_d[cmd_i.ba] = 1'b1;
      CMD_PRE: begin
        if (cmd_i.addr[AP_BIT]) begin
          bank_d = '0;
        end else begin
          bank_d[cmd_i.ba] = 1'b0;
        end
      end
      default: bank_d = bank_q;
    endcase
    if (sr_q || pd_q) begin
      bank_d = bank_q;
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cke_q   <= 1'b0;
      burst_q <= 3'h0;
      bank_q  <= '0;
      sr_q    <= 1'b0;
      pd_q    <= 1'b0;
    end else begin
      cke_q   <= cmd_i.cke;
      burst_q <= burst_d;
      bank_q  <= bank_d;
      if (op == CMD_SRE) begin
        sr_q <= 1'b1;
      end else if (sr_exit) begin
        sr_q <= 1'b0;
      end
      if (op == CMD_PDE && !sr_q) begin
        pd_q <= 1'b1;
      end else if (op == CMD_PDX) begin
        pd_q <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < MR_N; i++) begin : g_mr
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        mr_q[i] <= MR_RST;
      end else if (mr_wr && cmd_i.ba == BA_W'(i)) begin
        mr_q[i] <= cmd_i.addr[MR_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // pulses last one cycle; self refresh and power down levels hold until cke rises again
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bank_open_o     <= '0;
      burst_busy_o    <= 1'b0;
      self_refresh_o  <= 1'b0;
      power_down_o    <= 1'b0;
      term_on_o       <= 1'b0;
      refresh_pulse_o <= 1'b0;
      zq_short_o      <= 1'b0;
      zq_long_o       <= 1'b0;
      mode_regs_o     <= '0;
    end else begin
      bank_open_o     <= bank_d;
      burst_busy_o    <= (burst_d != 3'h0);
      self_refresh_o  <= (op == CMD_SRE) || (sr_q && !sr_exit);
      power_down_o    <= (op == CMD_PDE && !sr_q) || (pd_q && op != CMD_PDX);
      term_on_o       <= odt_i && !sr_q && (op != CMD_SRE);
      refresh_pulse_o <= (op == CMD_REF) && !pd_q;
      zq_short_o      <= (op == CMD_ZQCS);
      zq_long_o       <= (op == CMD_ZQCL);
      mode_regs_o     <= {mr_q[3], mr_q[2], mr_q[1], mr_q[0]};
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_zq_short_enc: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cke_q && cmd_i.cke && !cmd_i.cs_n && cmd_i.ras_n && cmd_i.cas_n && !cmd_i.we_n
     && !cmd_i.addr[AP_BIT]) |=> zq_short_o)
    else $error("zq short not flagged");

  chk_zq_long_enc: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (op == CMD_ZQCL) |=> (zq_long_o && !zq_short_o))
    else $error("zq long not flagged");

  chk_burst_runs: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rw_cmd && !burst_run && !chop && !sr_q && !pd_q) |=> burst_busy_o [*4])
    else $error("burst cut short");

  chk_nop_keeps: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ((op == CMD_NOP || op == CMD_DES) && burst_q > 3'h1) |=> burst_busy_o)
    else $error("nop ended a burst");

  chk_des_banks: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (op == CMD_DES) |=> (bank_q == $past(bank_q)))
    else $error("deselect changed banks");

  chk_sr_term: assert property (@(posedge core_clk_i) disable iff (rst_i)
    self_refresh_o |-> !term_on_o)
    else $error("termination in self refresh");

  chk_pd_norefresh: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pd_q |=> !refresh_pulse_o)
    else $error("refresh in power down");

  chk_mr_select: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mr_wr && cmd_i.ba == 3'h2) |=> ##1 (mode_regs_o[2*MR_W +: MR_W] == $past(cmd_i.addr, 2)))
    else $error("wrong mode register written");

  chk_sr_exit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (sr_q && cmd_i.cke) |=> !sr_q)
    else $error("self refresh exit missed");

  // ---------------------------------------------------------------
  // burst length and state checks
  // ---------------------------------------------------------------
  // length source: a12 per command in on-the-fly mode, else the register
  sequence s_otf_chop_start;
    rw_cmd && !sr_q && !pd_q && (bl_mode == MR0_BL_OTF) && !cmd_i.addr[BC_BIT];
  endsequence

  sequence s_fixed8_start;
    rw_cmd && !sr_q && !pd_q && (bl_mode != MR0_BL_OTF) && (bl_mode != MR0_BL_BC4);
  endsequence

  chk_otf_chop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_otf_chop_start |=> (burst_q == BURST4_CYC))
    else $error("on-the-fly chop length wrong");

  chk_fixed_len8: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_fixed8_start |=> (burst_q == BURST8_CYC))
    else $error("fixed burst length wrong");

  chk_burst_ends: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (burst_q == 3'h1 && !rw_cmd) |=> !burst_busy_o)
    else $error("burst overran its length");

  chk_term_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!sr_q && op != CMD_SRE) |=> (term_on_o == $past(odt_i)))
    else $error("termination ignored odt");

  chk_sre_state: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (op == CMD_SRE) |=> (self_refresh_o && !power_down_o && sr_q))
    else $error("self refresh entry missed");

endmodule : dcp_core

//--- design/dcp_pkg.sv
// Purpose: shared types and constants for the ddr3 command decoder
// Assumes: one rank, command pins sampled on rising core_clk_i
// Notes:   widths fixed at documented values
package dcp_pkg;

  localparam int BA_W   = 3;
  localparam int ADDR_W = 16;
  localparam int BANKS  = 8;
  localparam int MR_N   = 4;
  localparam int MR_W   = 16;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // mode register 0 burst length field, value 2'b01 selects on-the-fly
  localparam int MR0_BL_LO = 0;
  localparam logic [1:0] MR0_BL_OTF = 2'h1;
  localparam logic [1:0] MR0_BL_BC4 = 2'h2;
  localparam logic [MR_W-1:0] MR_RST = 16'h0000;
  // burst run length in clock cycles (8 beats, double rate)
  localparam logic [2:0] BURST8_CYC = 3'h4;
  localparam logic [2:0] BURST4_CYC = 3'h2;

  typedef struct packed {
    logic             cke;
    logic             cs_n;
    logic             ras_n;
    logic             cas_n;
    logic             we_n;
    logic [BA_W-1:0]  ba;
    logic [ADDR_W-1:0] addr;
  } dcp_cmd_t;

  typedef enum logic [3:0] {
    CMD_DES, CMD_NOP, CMD_MRS, CMD_REF, CMD_SRE, CMD_SRX, CMD_PRE,
    CMD_ACT, CMD_WR, CMD_RD, CMD_PDE, CMD_PDX, CMD_ZQCS, CMD_ZQCL, CMD_BAD
  } dcp_op_t;

endpackage : dcp_pkg

//--- design/dcp_decode.sv
// Purpose: combinational command decode from the sampled pins
// Assumes: previous clock enable supplied by caller
// Notes:   odt is deliberately not an input here
`timescale 1ns/10ps
module dcp_decode
  import dcp_pkg::*;
(
  input  wire dcp_cmd_t cmd_i,
  input  wire logic     cke_prev_i,
  output dcp_op_t       op_o
);

  wire [3:0] pins = {cmd_i.cs_n, cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
  wire       a10  = cmd_i.addr[AP_BIT];

  always_comb begin
    op_o = CMD_BAD;
    if (cke_prev_i && cmd_i.cke) begin
      if (pins[3]) begin
        op_o = CMD_DES;
      end else begin
        case (pins[2:0])
          3'h0: op_o = CMD_MRS;
          3'h1: op_o = CMD_REF;
          3'h2: op_o = CMD_PRE;
          3'h3: op_o = CMD_ACT;
          3'h4: op_o = CMD_WR;
          3'h5: op_o = CMD_RD;
          3'h6: op_o = a10 ? CMD_ZQCL : CMD_ZQCS;
          3'h7: op_o = CMD_NOP;
          default: op_o = CMD_BAD;
        endcase
      end
    end else if (cke_prev_i && !cmd_i.cke) begin
      if (!pins[3] && pins[2:0] == 3'h1) begin
        op_o = CMD_SRE;
      end else begin
        op_o = CMD_PDE;
      end
    end else if (!cke_prev_i && cmd_i.cke) begin
      op_o = CMD_PDX;
    end else begin
      op_o = CMD_NOP;
    end
  end

endmodule : dcp_decode

//--- tb/dcp_ctrl_model.sv
// Purpose: controller model that puts each requested command on the pins
// Assumes: op_i changes just after a rising edge and holds for one cycle
// Notes:   don't-care pins toggle every cycle for deselect and self refresh exit; power down entry and exit leave them static
`timescale 1ns/10ps
module dcp_ctrl_model
  import dcp_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire dcp_op_t           op_i,
  input  wire logic [BA_W-1:0]   ba_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output dcp_cmd_t               cmd_o
);
  logic              asleep_q = 1'h0;
  logic [2:0]        junk_q   = 3'h5;
  logic [3:0]        pins;
  logic              cke;
  logic [ADDR_W-1:0] a;

  // clock enable stays low for the whole of power down and self refresh
  always @(posedge core_clk_i) begin
    junk_q <= ~junk_q;
    if (op_i inside {CMD_SRE, CMD_PDE}) asleep_q <= 1'h1;
    if (op_i inside {CMD_SRX, CMD_PDX}) asleep_q <= 1'h0;
  end

  // pins are cs, ras, cas, we, all active low
  always_comb begin
    cke  = ~asleep_q;
    pins = 4'h7;
    a    = addr_i;
    case (op_i)
      CMD_DES: pins = {1'h1, junk_q};
      CMD_SRX: begin
        cke  = 1'h1;
        pins = {1'h1, junk_q};
      end
      CMD_SRE: begin
        cke  = 1'h0;
        pins = 4'h1;
      end
      CMD_PDE: cke = 1'h0;
      CMD_PDX: cke = 1'h1;
      CMD_MRS: pins = 4'h0;
      CMD_REF: pins = 4'h1;
      CMD_PRE: pins = 4'h2;
      CMD_ACT: pins = 4'h3;
      CMD_WR:  pins = 4'h4;
      CMD_RD:  pins = 4'h5;
      CMD_ZQCS, CMD_ZQCL: begin
        pins      = 4'h6;
        a[AP_BIT] = (op_i == CMD_ZQCL);
      end
      default: pins = 4'h7;
    endcase
  end

  // valid fields come straight from the bench, never floating
  assign cmd_o = '{cke: cke, cs_n: pins[3], ras_n: pins[2], cas_n: pins[1],
                   we_n: pins[0], ba: ba_i, addr: a};
endmodule : dcp_ctrl_model

//--- tb/tb_top.sv
// Purpose: self-checking bench for the ddr3 command decoder
// Assumes: the controller model encodes every command on the pins
// Notes:   odt is random every cycle, so it must never steer decode
`timescale 1ns/10ps
module tb_top
  import dcp_pkg::*;
;
  logic                 core_clk_i, rst_i, odt_i;
  dcp_op_t              op;
  logic [BA_W-1:0]      ba, b;
  logic [ADDR_W-1:0]    addr, v;
  dcp_cmd_t             cmd;
  logic [BANKS-1:0]     bank_open, exp_bank;
  logic                 busy, sr, pd, term, refp, zqs, zql;
  logic [MR_N*MR_W-1:0] mr_all;
  logic [MR_W-1:0]      exp_mr [MR_N];
  int                   mismatches, checked, cycles, n;

  // evaluated at the call so a just-updated expectation is never stale
  function automatic logic [MR_N*MR_W-1:0] mr_pack();
    return {exp_mr[3], exp_mr[2], exp_mr[1], exp_mr[0]};
  endfunction : mr_pack
  dcp_ctrl_model u_dcp_ctrl_model (.core_clk_i(core_clk_i), .op_i(op), .ba_i(ba),
    .addr_i(addr), .cmd_o(cmd));
  dcp_core u_dcp_core (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_i(cmd), .odt_i(odt_i),
    .bank_open_o(bank_open), .burst_busy_o(busy), .self_refresh_o(sr), .power_down_o(pd),
    .term_on_o(term), .refresh_pulse_o(refp), .zq_short_o(zqs), .zq_long_o(zql),
    .mode_regs_o(mr_all));

  initial begin
    core_clk_i = 1'h0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (exp !== got) begin
      mismatches++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask : chk
  // one command per cycle; returns just after the edge that took it
  task automatic issue(input dcp_op_t o, input logic [2:0] bb, input logic [15:0] aa);
    op    = o;
    ba    = bb;
    addr  = aa;
    odt_i = 1'($urandom);
    @(posedge core_clk_i);
    #1;
  endtask : issue
  task automatic rnd_issue(input dcp_op_t o);
    issue(o, 3'($urandom), 16'($urandom));
  endtask : rnd_issue
  task automatic idle();
    rnd_issue(($urandom % 2) ? CMD_NOP : CMD_DES);
  endtask : idle
  function automatic int blen(input logic [1:0] bl, input logic a12);
    if (bl == MR0_BL_OTF) return a12 ? int'(BURST8_CYC) : int'(BURST4_CYC);
    return (bl == MR0_BL_BC4) ? int'(BURST4_CYC) : int'(BURST8_CYC);
  endfunction : blen

  initial begin
    void'($urandom(32'h49cc));
    rst_i    = 1'h1;
    odt_i    = 1'h0;
    op       = CMD_NOP;
    ba       = 3'h0;
    addr     = 16'h0;
    exp_bank = '0;
    foreach (exp_mr[k]) exp_mr[k] = MR_RST;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_i = 1'h0;
    chk({bank_open, busy, sr, pd, term, refp, zqs, zql}, 15'h0);
    chk(mr_all, mr_pack());
    repeat (2) idle();
    for (int i = 0; i < 6; i++) begin
      b = (i < 4) ? 3'(i) : 3'h2;
      v = 16'($urandom);
      if (b == 3'h2) v[7:6] = (i == 2) ? 2'h2 : 2'h1;
      issue(CMD_MRS, b, v);
      idle();
      exp_mr[b[1:0]] = v;
      chk(mr_all, mr_pack());
    end
    $display("test mode registers done");
    repeat (6) begin
      b = 3'($urandom);
      rnd_issue(CMD_ACT);
      exp_bank[ba] = 1'h1;
      issue(CMD_ACT, b, 16'($urandom));
      exp_bank[b] = 1'h1;
      chk(bank_open, exp_bank);
    end
    issue(CMD_PRE, b, 16'($urandom) & 16'hfbff);
    exp_bank[b] = 1'h0;
    chk(bank_open, exp_bank);
    issue(CMD_PRE, 3'($urandom), 16'h0400);
    chk(bank_open, 8'h0);
    $display("test banks done");
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom);
      v[1:0] = 2'(i / 2);
      issue(CMD_MRS, 3'h0, v);
      idle();
      n = blen(v[1:0], i[0]);
      v = 16'($urandom);
      v[BC_BIT] = i[0];
      v[AP_BIT] = 1'h0;
      issue((i < 3) ? CMD_RD : CMD_WR, 3'($urandom), v);
      for (int j = 0; j < n; j++) begin
        chk(busy, 1'h1);
        if (j == 1) issue(CMD_PRE, 3'h0, 16'h0400);
        else idle();
      end
      chk(busy, 1'h0);
    end
    $display("test bursts done");
    issue(CMD_PRE, 3'h0, 16'h0400);
    repeat (2) begin
      rnd_issue(CMD_REF);
      chk(refp, 1'h1);
    end
    rnd_issue(CMD_ZQCS);
    chk({refp, zqs, zql}, 3'h2);
    rnd_issue(CMD_ZQCL);
    chk({zqs, zql}, 2'h1);
    idle();
    chk({zqs, zql}, 2'h0);
    $display("test refresh and calibration done");
    rnd_issue(CMD_SRE);
    chk({sr, pd}, 2'h2);
    repeat (4) begin
      rnd_issue(($urandom % 2) ? CMD_RD : CMD_ACT);
      chk({sr, term, busy, bank_open}, {1'h1, 10'h0});
    end
    rnd_issue(CMD_SRX);
    chk(sr, 1'h0);
    repeat (3) begin
      idle();
      chk(term, odt_i);
    end
    rnd_issue(CMD_PDE);
    chk(pd, 1'h1);
    rnd_issue(CMD_REF);
    chk({refp, pd}, 2'h1);
    rnd_issue(CMD_PDX);
    chk(pd, 1'h0);
    $display("test low power done");
    op    = CMD_NOP;
    rst_i = 1'h1;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_i = 1'h0;
    foreach (exp_mr[k]) exp_mr[k] = MR_RST;
    chk({bank_open, busy, sr, pd, term, refp, zqs, zql}, 15'h0);
    chk(mr_all, mr_pack());
    repeat (2) idle();
    rnd_issue(CMD_ZQCL);
    chk({zqs, zql}, 2'h1);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : tb_top
